// ---- logic/cabbe_map.svh ----
/*
 * Constants of the arithmetic, bit and branch execution block: register offsets,
 * field positions, reset values, opcodes and cycle counts.
 * Assumes inclusion by cabbe_pkg, the block's design files and the testbench.
 */
`ifndef CABBE_MAP_SVH
`define CABBE_MAP_SVH

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define CABBE_CTRL_OFS        12'h000
`define CABBE_INSTR_OFS       12'h004
`define CABBE_ACC_OFS         12'h008
`define CABBE_STAT_OFS        12'h00C
`define CABBE_PROG_CNT_OFS    12'h010
`define CABBE_INFO_OFS        12'h014
`define CABBE_FILE_BASE       12'h200

// ************************************************************
// Fields and reset values
// ************************************************************
`define CABBE_CTRL_GO_BIT     0
`define CABBE_STAT_CARRY_BIT  0
`define CABBE_STAT_HALF_BIT   1
`define CABBE_STAT_ZERO_BIT   2
`define CABBE_PROG_CNT_W      15
`define CABBE_PROG_CNT_RST    15'h0000
`define CABBE_ACC_RST         8'h00
`define CABBE_STAT_RST        3'h0
`define CABBE_FILE_RST        8'h00
`define CABBE_FILE_DEPTH      128
`define CABBE_FILE_AW         7
`define CABBE_OFFSET_W        9

// ************************************************************
// Opcodes, bus answers and cycle counts
// ************************************************************
`define CABBE_OP_NOP          3'h0
`define CABBE_OP_ADD          3'h1
`define CABBE_OP_ADDC         3'h2
`define CABBE_OP_ASHR         3'h3
`define CABBE_OP_BCLR         3'h4
`define CABBE_OP_BTSC         3'h5
`define CABBE_OP_RBR          3'h6
`define CABBE_RESP_OKAY       2'h0
`define CABBE_RESP_SLVERR     2'h2
`define CABBE_CYC_ONE         2'h1
`define CABBE_CYC_TWO         2'h2

`endif

// ---- logic/cabbe_pkg.sv ----
/*
 * Types of the execution block: opcodes, states, instruction word and bus carriers.
 * Assumes cabbe_map.svh is on the include path.
 */
package cabbe_pkg;
`include "cabbe_map.svh"

    typedef enum logic [2:0] {
        OP_NOP                    = `CABBE_OP_NOP,
        OP_ADD_ACC_FILE           = `CABBE_OP_ADD,
        OP_ADD_ACC_FILE_CARRY     = `CABBE_OP_ADDC,
        OP_ARITH_SHIFT_RIGHT_FILE = `CABBE_OP_ASHR,
        OP_BIT_CLEAR_FILE         = `CABBE_OP_BCLR,
        OP_BIT_TEST_SKIP_CLEAR    = `CABBE_OP_BTSC,
        OP_RELATIVE_BRANCH        = `CABBE_OP_RBR
    } cabbe_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_NOPC = 3'b100
    } cabbe_state_t;

    typedef struct packed {
        logic [`CABBE_OFFSET_W-1:0] offset;
        logic [`CABBE_FILE_AW-1:0]  file;
        logic [2:0]                 bsel;
        logic                       dest;
        cabbe_op_t                  op;
    } cabbe_instr_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [2:0]  prot;
    } cabbe_addr_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  strb;
    } cabbe_wdata_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } cabbe_rdata_t;

endpackage : cabbe_pkg

// ---- logic/cabbe_alu.sv ----
/*
 * Result and flag logic for add, add with carry, arithmetic shift, bit clear
 * and bit test. Purely combinational; the caller registers the result, the flags and the skip.
 */
`timescale 1ns/1ps
`include "cabbe_map.svh"

module cabbe_alu (
    input  wire cabbe_pkg::cabbe_op_t op_i,
    input  wire logic [7:0]           acc_i,
    input  wire logic [7:0]           fval_i,
    input  wire logic [2:0]           bsel_i,
    input  wire logic                 dest_i,
    input  wire logic                 carry_i,
    output logic [7:0]                res_o,
    output logic [2:0]                flags_o,
    output logic [2:0]                flag_we_o,
    output logic                      acc_we_o,
    output logic                      file_we_o,
    output logic                      skip_o
);
    logic [8:0] sum9;
    logic [4:0] low5;
    logic       cin;
    logic       is_add;
    logic       is_ashr;
    logic       is_bclr;
    logic       arith;

    assign is_add  = (op_i == cabbe_pkg::OP_ADD_ACC_FILE) ||
                     (op_i == cabbe_pkg::OP_ADD_ACC_FILE_CARRY);
    assign is_ashr = (op_i == cabbe_pkg::OP_ARITH_SHIFT_RIGHT_FILE);
    assign is_bclr = (op_i == cabbe_pkg::OP_BIT_CLEAR_FILE);
    assign arith   = is_add || is_ashr;
    assign cin     = (op_i == cabbe_pkg::OP_ADD_ACC_FILE_CARRY) && carry_i;
    assign sum9    = {1'b0, acc_i} + {1'b0, fval_i} + {8'h00, cin};
    assign low5    = {1'b0, acc_i[3:0]} + {1'b0, fval_i[3:0]} + {4'h0, cin};

    assign res_o = is_add  ? sum9[7:0] :
                   is_ashr ? {fval_i[7], fval_i[7:1]} :
                   fval_i & ~(8'h01 << bsel_i);

    assign flags_o[`CABBE_STAT_CARRY_BIT] = is_add ? sum9[8] : fval_i[0];
    assign flags_o[`CABBE_STAT_HALF_BIT]  = low5[4];
    assign flags_o[`CABBE_STAT_ZERO_BIT]  = (res_o == 8'h00);

    // Shift leaves the half carry alone; bit ops touch no flag
    assign flag_we_o[`CABBE_STAT_CARRY_BIT] = arith;
    assign flag_we_o[`CABBE_STAT_HALF_BIT]  = is_add;
    assign flag_we_o[`CABBE_STAT_ZERO_BIT]  = arith;

    assign acc_we_o  = arith && !dest_i;
    assign file_we_o = (arith && dest_i) || is_bclr;
    assign skip_o    = (op_i == cabbe_pkg::OP_BIT_TEST_SKIP_CLEAR) && !fval_i[bsel_i];

endmodule : cabbe_alu

// ---- logic/cabbe_target.sv ----
/*
 * Next program counter and cycle length of an executed instruction.
 * Assumes the program counter given is that of the executing instruction.
 */
`timescale 1ns/1ps
`include "cabbe_map.svh"

module cabbe_target (
    input  wire logic [`CABBE_PROG_CNT_W-1:0] program_counter_i,
    input  wire logic [`CABBE_OFFSET_W-1:0]   offset_i,
    input  wire cabbe_pkg::cabbe_op_t         op_i,
    input  wire logic                         skip_i,
    output logic [`CABBE_PROG_CNT_W-1:0]      next_o,
    output logic                              two_cyc_o
);
    logic [`CABBE_PROG_CNT_W-1:0] inc;
    logic [`CABBE_PROG_CNT_W-1:0] sext;
    logic                         branch;

    assign branch    = (op_i == cabbe_pkg::OP_RELATIVE_BRANCH);
    assign inc       = program_counter_i + `CABBE_PROG_CNT_W'(1);
    assign sext      = {{(`CABBE_PROG_CNT_W-`CABBE_OFFSET_W){offset_i[8]}}, offset_i};
    assign next_o    = branch ? inc + sext :
                       skip_i ? inc + `CABBE_PROG_CNT_W'(1) : inc;
    assign two_cyc_o = branch || skip_i;

endmodule : cabbe_target

// ---- logic/cabbe_exec.sv ----
/*
 * Execution block for add, add with carry, arithmetic shift right, bit clear,
 * bit test with skip and relative branch, with a 128-byte file bank, an
 * accumulator, status flags and a program counter, all reached over AXI4-Lite.
 * Assumes one 125 MHz clock, a synchronous active-low reset and a bus master
 * that keeps to the AXI4-Lite handshake.
 */
// Behaviour
// - Add sums accumulator and file, sets flags
// - Destination bit picks accumulator or file
// - Add with carry includes current carry
// - Shift right keeps bit 7, bit0 to carry
// - Shift changes only carry and zero
// - Bit clear zeroes one bit, no flags
// - Bit test skips next when bit clear
// - Taken skip inserts nop, two cycles
// - Branch target counter plus one plus offset
// - Branch takes two cycles, no flags
// - Counter change or true test adds nop
`timescale 1ns/1ps
`include "cabbe_map.svh"

module cabbe_exec (
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    s_axi_awvalid_i,
    output logic                         s_axi_awready_o,
    input  wire cabbe_pkg::cabbe_addr_t  s_axi_aw_i,
    input  wire logic                    s_axi_wvalid_i,
    output logic                         s_axi_wready_o,
    input  wire cabbe_pkg::cabbe_wdata_t s_axi_w_i,
    output logic                         s_axi_bvalid_o,
    input  wire logic                    s_axi_bready_i,
    output logic [1:0]                   s_axi_bresp_o,
    input  wire logic                    s_axi_arvalid_i,
    output logic                         s_axi_arready_o,
    input  wire cabbe_pkg::cabbe_addr_t  s_axi_ar_i,
    output logic                         s_axi_rvalid_o,
    input  wire logic                    s_axi_rready_i,
    output cabbe_pkg::cabbe_rdata_t      s_axi_r_o,
    output logic                         busy_o,
    output logic [`CABBE_PROG_CNT_W-1:0] program_counter_o
);

    // ************************************************************
    // State
    // ************************************************************
    logic                         aw_full_q;
    logic [11:0]                  aw_addr_q;
    logic                         w_full_q;
    cabbe_pkg::cabbe_wdata_t      w_q;
    logic                         bvalid_q;
    logic [1:0]                   bresp_q;
    logic                         rvalid_q;
    cabbe_pkg::cabbe_rdata_t      r_q;
    cabbe_pkg::cabbe_instr_t      instr_q;
    logic [7:0]                   acc_q;
    logic [7:0]                   acc_d;
    logic [2:0]                   stat_q;
    logic [2:0]                   stat_d;
    logic [`CABBE_PROG_CNT_W-1:0] program_counter_q;
    logic [`CABBE_PROG_CNT_W-1:0] program_counter_d;
    cabbe_pkg::cabbe_state_t      st_q;
    cabbe_pkg::cabbe_state_t      st_d;
    logic                         skip_last_q;
    logic [1:0]                   cyc_last_q;
    logic [7:0]                   mem_q [`CABBE_FILE_DEPTH];

    // ************************************************************
    // Write decode
    // ************************************************************
    logic        idle;
    logic        ex;
    logic        wr_fire;
    logic [31:0] wmask;
    logic        wa_ctrl;
    logic        wa_instr;
    logic        wa_acc;
    logic        wa_stat;
    logic        wa_cnt;
    logic        wa_info;
    logic        wa_file;
    logic        wr_map;
    logic        go;
    logic [31:0] mrg_instr;
    logic [31:0] mrg_acc;
    logic [31:0] mrg_stat;
    logic [31:0] mrg_cnt;

    assign idle     = (st_q == cabbe_pkg::ST_IDLE);
    assign ex       = (st_q == cabbe_pkg::ST_EXEC);
    assign wr_fire  = aw_full_q && w_full_q && !bvalid_q && idle;
    assign wmask    = {{8{w_q.strb[3]}}, {8{w_q.strb[2]}}, {8{w_q.strb[1]}}, {8{w_q.strb[0]}}};
    assign wa_ctrl  = (aw_addr_q[11:2] == `CABBE_CTRL_OFS >> 2);
    assign wa_instr = (aw_addr_q[11:2] == `CABBE_INSTR_OFS >> 2);
    assign wa_acc   = (aw_addr_q[11:2] == `CABBE_ACC_OFS >> 2);
    assign wa_stat  = (aw_addr_q[11:2] == `CABBE_STAT_OFS >> 2);
    assign wa_cnt   = (aw_addr_q[11:2] == `CABBE_PROG_CNT_OFS >> 2);
    assign wa_info  = (aw_addr_q[11:2] == `CABBE_INFO_OFS >> 2);
    assign wa_file  = (aw_addr_q[11:9] == `CABBE_FILE_BASE >> 9);
    assign wr_map   = wa_ctrl || wa_instr || wa_acc || wa_stat || wa_cnt || wa_info || wa_file;
    assign go       = wr_fire && wa_ctrl && w_q.strb[0] && w_q.data[`CABBE_CTRL_GO_BIT];
    assign mrg_instr = ({9'h000, instr_q} & ~wmask) | (w_q.data & wmask);
    assign mrg_acc   = ({24'h000000, acc_q} & ~wmask) | (w_q.data & wmask);
    assign mrg_stat  = ({29'h00000000, stat_q} & ~wmask) | (w_q.data & wmask);
    assign mrg_cnt   = ({17'h00000, program_counter_q} & ~wmask) | (w_q.data & wmask);

    // ************************************************************
    // Write channels
    // ************************************************************
    assign s_axi_awready_o = !aw_full_q;
    assign s_axi_wready_o  = !w_full_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_full_q  <= 1'b0;
            w_q       <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `CABBE_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && !aw_full_q) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_aw_i.addr;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid_i && !w_full_q) begin
                w_full_q <= 1'b1;
                w_q      <= s_axi_w_i;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_map ? `CABBE_RESP_OKAY : `CABBE_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Read channels
    // ************************************************************
    logic [31:0] rd_data;
    logic        rd_ok;
    logic [11:0] ra;

    assign ra              = s_axi_ar_i.addr;
    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_r_o       = r_q;

    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h00000000;
        if (ra[11:2] == `CABBE_CTRL_OFS >> 2) begin
            rd_data = 32'h00000000;
        end else if (ra[11:2] == `CABBE_INSTR_OFS >> 2) begin
            rd_data = {9'h000, instr_q};
        end else if (ra[11:2] == `CABBE_ACC_OFS >> 2) begin
            rd_data = {24'h000000, acc_q};
        end else if (ra[11:2] == `CABBE_STAT_OFS >> 2) begin
            rd_data = {29'h00000000, stat_q};
        end else if (ra[11:2] == `CABBE_PROG_CNT_OFS >> 2) begin
            rd_data = {17'h00000, program_counter_q};
        end else if (ra[11:2] == `CABBE_INFO_OFS >> 2) begin
            rd_data = {28'h0000000, cyc_last_q, skip_last_q, !idle};
        end else if (ra[11:9] == `CABBE_FILE_BASE >> 9) begin
            rd_data = {24'h000000, mem_q[ra[8:2]]};
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            r_q      <= '0;
        end else if (s_axi_arvalid_i && !rvalid_q) begin
            rvalid_q <= 1'b1;
            r_q.data <= rd_data;
            r_q.resp <= rd_ok ? `CABBE_RESP_OKAY : `CABBE_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end

    // ************************************************************
    // Execution datapath
    // ************************************************************
    logic [7:0]                   fval;
    logic [7:0]                   res;
    logic [2:0]                   flags;
    logic [2:0]                   flag_we;
    logic                         acc_we;
    logic                         file_we;
    logic                         skip;
    logic [`CABBE_PROG_CNT_W-1:0] next_cnt;
    logic                         two_cyc;

    assign fval = mem_q[instr_q.file];

    cabbe_alu u_alu (
        .op_i      (instr_q.op),
        .acc_i     (acc_q),
        .fval_i    (fval),
        .bsel_i    (instr_q.bsel),
        .dest_i    (instr_q.dest),
        .carry_i   (stat_q[`CABBE_STAT_CARRY_BIT]),
        .res_o     (res),
        .flags_o   (flags),
        .flag_we_o (flag_we),
        .acc_we_o  (acc_we),
        .file_we_o (file_we),
        .skip_o    (skip)
    );

    cabbe_target u_target (
        .program_counter_i (program_counter_q),
        .offset_i          (instr_q.offset),
        .op_i              (instr_q.op),
        .skip_i            (skip),
        .next_o            (next_cnt),
        .two_cyc_o         (two_cyc)
    );

    assign acc_d  = (ex && acc_we) ? res :
                    (wr_fire && wa_acc) ? mrg_acc[7:0] : acc_q;
    assign stat_d = ex ? ((stat_q & ~flag_we) | (flags & flag_we)) :
                    (wr_fire && wa_stat) ? mrg_stat[2:0] : stat_q;
    assign program_counter_d = ex ? next_cnt :
                               (wr_fire && wa_cnt) ? mrg_cnt[`CABBE_PROG_CNT_W-1:0] :
                               program_counter_q;

    always_comb begin
        case (st_q)
            cabbe_pkg::ST_IDLE: st_d = go ? cabbe_pkg::ST_EXEC : cabbe_pkg::ST_IDLE;
            cabbe_pkg::ST_EXEC: st_d = two_cyc ? cabbe_pkg::ST_NOPC : cabbe_pkg::ST_IDLE;
            cabbe_pkg::ST_NOPC: st_d = cabbe_pkg::ST_IDLE;
            default:            st_d = cabbe_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_q              <= cabbe_pkg::ST_IDLE;
            instr_q           <= '0;
            acc_q             <= `CABBE_ACC_RST;
            stat_q            <= `CABBE_STAT_RST;
            program_counter_q <= `CABBE_PROG_CNT_RST;
            skip_last_q       <= 1'b0;
            cyc_last_q        <= 2'h0;
        end else begin
            st_q              <= st_d;
            acc_q             <= acc_d;
            stat_q            <= stat_d;
            program_counter_q <= program_counter_d;
            if (wr_fire && wa_instr) begin
                instr_q <= cabbe_pkg::cabbe_instr_t'(mrg_instr[22:0]);
            end
            if (ex) begin
                skip_last_q <= skip;
                cyc_last_q  <= two_cyc ? `CABBE_CYC_TWO : `CABBE_CYC_ONE;
            end
        end
    end

    // ************************************************************
    // File bank
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `CABBE_FILE_DEPTH; gi++) begin : g_file
            always_ff @(posedge core_clk_i) begin
                if (!rst_n_i) begin
                    mem_q[gi] <= `CABBE_FILE_RST;
                end else if (ex && file_we && instr_q.file == gi) begin
                    mem_q[gi] <= res;
                end else if (wr_fire && wa_file && aw_addr_q[8:2] == gi) begin
                    mem_q[gi] <= (mem_q[gi] & ~wmask[7:0]) | (w_q.data[7:0] & wmask[7:0]);
                end
            end
        end
    endgenerate

    assign busy_o            = !idle;
    assign program_counter_o = program_counter_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    add_result_a: assert property (
        ex && instr_q.op == cabbe_pkg::OP_ADD_ACC_FILE && !instr_q.dest
        |=> acc_q == 8'($past(acc_q) + $past(fval)))
        else $error("add result wrong");

    dest_file_a: assert property (
        ex && instr_q.dest && instr_q.op inside {cabbe_pkg::OP_ADD_ACC_FILE,
            cabbe_pkg::OP_ADD_ACC_FILE_CARRY, cabbe_pkg::OP_ARITH_SHIFT_RIGHT_FILE}
        |=> $stable(acc_q) && mem_q[instr_q.file] == $past(res))
        else $error("file destination not honoured");

    addc_result_a: assert property (
        ex && instr_q.op == cabbe_pkg::OP_ADD_ACC_FILE_CARRY && !instr_q.dest
        |=> acc_q == 8'($past(acc_q) + $past(fval) + {7'h00, $past(stat_q[0])}))
        else $error("add with carry result wrong");

    shift_value_a: assert property (
        ex && instr_q.op == cabbe_pkg::OP_ARITH_SHIFT_RIGHT_FILE && !instr_q.dest
        |=> acc_q == {$past(fval[7]), $past(fval[7:1])} && stat_q[0] == $past(fval[0]))
        else $error("shift value or carry wrong");

    shift_flags_a: assert property (
        ex && instr_q.op == cabbe_pkg::OP_ARITH_SHIFT_RIGHT_FILE
        |=> stat_q[1] == $past(stat_q[1]) && stat_q[2] == ($past(fval[7:1]) == 7'h00))
        else $error("shift touched half carry");

    bit_clear_a: assert property (
        ex && instr_q.op == cabbe_pkg::OP_BIT_CLEAR_FILE
        |=> mem_q[instr_q.file] == ($past(fval) & ~(8'h01 << instr_q.bsel))
            && $stable(stat_q))
        else $error("bit clear wrong");

    no_skip_a: assert property (
        ex && instr_q.op == cabbe_pkg::OP_BIT_TEST_SKIP_CLEAR && fval[instr_q.bsel]
        |=> idle && program_counter_q == $past(program_counter_q) + 15'h0001)
        else $error("test with set bit skipped");

    skip_nop_a: assert property (
        ex && instr_q.op == cabbe_pkg::OP_BIT_TEST_SKIP_CLEAR && !fval[instr_q.bsel]
        |=> st_q == cabbe_pkg::ST_NOPC && $stable(stat_q) && program_counter_q
            == $past(program_counter_q) + 15'h0002 ##1 idle && $stable(acc_q))
        else $error("taken skip not two cycles");

    branch_target_a: assert property (
        ex && instr_q.op == cabbe_pkg::OP_RELATIVE_BRANCH
        |=> program_counter_q == $past(program_counter_q) + 15'h0001
            + {{6{instr_q.offset[8]}}, instr_q.offset})
        else $error("branch target wrong");

    branch_cycles_a: assert property (
        ex && instr_q.op == cabbe_pkg::OP_RELATIVE_BRANCH
        |=> !idle && $stable(stat_q) ##1 idle && $stable(stat_q) && cyc_last_q == 2'h2)
        else $error("branch not two cycles");

    zero_flag_a: assert property (
        ex && (instr_q.op == cabbe_pkg::OP_ADD_ACC_FILE
            || instr_q.op == cabbe_pkg::OP_ADD_ACC_FILE_CARRY)
        |=> stat_q[2] == ((instr_q.dest ? mem_q[instr_q.file] : acc_q) == 8'h00)
            && stat_q[1] == (5'($past(acc_q[3:0]) + $past(fval[3:0])
            + $past(instr_q.op[1] & stat_q[0])) > 5'h0F))
        else $error("add flags wrong");

    nop_cycle_a: assert property (
        st_q == cabbe_pkg::ST_NOPC
        |=> $stable(acc_q) && $stable(stat_q) && $stable(program_counter_q) && idle)
        else $error("second cycle not a no-op");

endmodule : cabbe_exec

// ---- tb/tb_top.sv ----
/*
 * Self-checking bench of the execution block: AXI4-Lite master tasks and scenarios.
 * Assumes the package, the map header and the design files are compiled first.
 */
`timescale 1ns/1ps
`include "cabbe_map.svh"

module tb_top;
    logic                    clk   = 1'b0;
    logic                    rst_n = 1'b0;
    logic                    awv   = 1'b0;
    logic                    wv    = 1'b0;
    logic                    arv   = 1'b0;
    logic                    awr, wrdy, bv, arr, rv, busy;
    logic [1:0]              br, rs;
    logic [14:0]             pc;
    logic [31:0]             d;
    cabbe_pkg::cabbe_addr_t  aw = '0;
    cabbe_pkg::cabbe_addr_t  ar = '0;
    cabbe_pkg::cabbe_wdata_t w  = '0;
    cabbe_pkg::cabbe_rdata_t r;
    int                      errors = 0;
    int                      comparisons = 0;

    always #4 clk = ~clk;

    cabbe_exec i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_aw_i(aw), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
        .s_axi_w_i(w), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1), .s_axi_bresp_o(br),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_ar_i(ar), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(1'b1), .s_axi_r_o(r), .busy_o(busy), .program_counter_o(pc));

    // ************************************************************
    // Bus and compare tasks
    // ************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task bus_wr(input logic [11:0] a, input logic [31:0] v);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        aw <= '{a, 3'h0};
        w <= '{v, 4'hF};
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            ad = ad | awr;
            wd = wd | wrdy;
            if (ad) awv <= 1'b0;
            if (wd) wv <= 1'b0;
        end
        do @(posedge clk); while (bv !== 1'b1);
        rs = br;
    endtask : bus_wr

    task bus_rd(input logic [11:0] a);
        ar <= '{a, 3'h0};
        arv <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        d = r.data;
        rs = r.resp;
    endtask : bus_rd

    task rchk(input logic [11:0] a, input logic [31:0] exp);
        bus_rd(a);
        chk(d, exp);
    endtask : rchk

    task run(input logic [2:0] op, input logic dst, input logic [2:0] b, input logic [8:0] k);
        bus_wr(12'h004, {9'h0, k, 7'h7F, b, dst, op});
        bus_wr(12'h000, 32'h1);
        chk({31'h0, busy}, 32'h1);
        while (busy !== 1'b0) @(posedge clk);
    endtask : run

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_bus;
        rchk(12'h008, 32'h0);
        bus_wr(12'h100, 32'h1);
        chk({30'h0, rs}, 32'h2);
        rchk(12'h100, 32'h0);
        chk({30'h0, rs}, 32'h2);
    endtask : t_bus

    task t_add;
        bus_wr(12'h008, 32'h8F);
        bus_wr(12'h3FC, 32'h71);
        run(`CABBE_OP_ADD, 1'b0, 3'h0, 9'h0);
        rchk(12'h008, 32'h0);
        rchk(12'h00C, 32'h7);
        rchk(12'h3FC, 32'h71);
        run(`CABBE_OP_ADDC, 1'b1, 3'h0, 9'h0);
        rchk(12'h3FC, 32'h72);
        rchk(12'h00C, 32'h0);
    endtask : t_add

    task t_shift;
        bus_wr(12'h3FC, 32'h81);
        bus_wr(12'h00C, 32'h2);
        run(`CABBE_OP_ASHR, 1'b0, 3'h0, 9'h0);
        rchk(12'h008, 32'hC0);
        rchk(12'h00C, 32'h3);
        rchk(12'h014, 32'h4);
    endtask : t_shift

    task t_bits;
        bus_wr(12'h00C, 32'h5);
        bus_wr(12'h010, 32'h20);
        run(`CABBE_OP_BCLR, 1'b0, 3'h7, 9'h0);
        rchk(12'h3FC, 32'h01);
        rchk(12'h00C, 32'h5);
        run(`CABBE_OP_BTSC, 1'b0, 3'h0, 9'h0);
        chk({17'h0, pc}, 32'h22);
        run(`CABBE_OP_BTSC, 1'b0, 3'h7, 9'h0);
        chk({17'h0, pc}, 32'h24);
        rchk(12'h014, 32'hA);
    endtask : t_bits

    task t_branch;
        bus_wr(12'h010, 32'h5);
        run(`CABBE_OP_RBR, 1'b0, 3'h0, 9'h100);
        chk({17'h0, pc}, 32'h7F06);
        rchk(12'h014, 32'h8);
        run(`CABBE_OP_RBR, 1'b0, 3'h0, 9'h0FF);
        chk({17'h0, pc}, 32'h6);
        rchk(12'h00C, 32'h5);
        run(`CABBE_OP_NOP, 1'b0, 3'h0, 9'h0);
        chk({17'h0, pc}, 32'h7);
    endtask : t_branch

    task finish_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_bus;
        t_add;
        t_shift;
        t_bits;
        t_branch;
        finish_test;
    end

    initial begin
        #200000;
        errors++;
        finish_test;
    end
endmodule : tb_top
